// file: dspid_consts.svh
// Opcode encodings, field positions and reset values of the instruction decoder
`ifndef DSPID_CONSTS_SVH
`define DSPID_CONSTS_SVH
`define DSPID_OP_ABS 16'h7f88
`define DSPID_OP_ZAC 16'h7f89
`define DSPID_OP_CALL_FROM_ACCUMULATOR 16'h7f8c
`define DSPID_OP_RET 16'h7f8d
`define DSPID_NIB_ADD 4'h0
`define DSPID_NIB_SUB 4'h1
`define DSPID_NIB_LAC 4'h2
`define DSPID_TOP5_STORE_HIGH_SHIFTED 5'h0b
`define DSPID_OP_STORE_LOW_WORD 8'h50
`define DSPID_OP_HIGH_PLUS_OP 8'h60
`define DSPID_OP_UNSIGNED_PLUS_OP 8'h61
`define DSPID_OP_HIGH_MINUS_OP 8'h62
`define DSPID_OP_UNSIGNED_MINUS_OP 8'h63
`define DSPID_OP_CONDITIONAL_SUBTRACT_OP 8'h64
`define DSPID_OP_CLEAR_LOAD_HIGH_OP 8'h65
`define DSPID_OP_CLEAR_LOAD_LOW_OP 8'h66
`define DSPID_OP_MAR 8'h68
`define DSPID_OP_PAGE_PTR_LOAD_IMM 8'h6e
`define DSPID_OP_LDP 8'h6f
`define DSPID_TOP7_AUX_LOAD_IMMEDIATE 7'h38
`define DSPID_OP_LOAD_IMM_TO_ACC 8'h7e
`define DSPID_OP_XOR 8'h78
`define DSPID_OP_AND 8'h79
`define DSPID_OP_OR 8'h7a
`define DSPID_OP_BRANCH_AUX_NONZERO 8'hf4
`define DSPID_OP_BV 8'hf5
`define DSPID_OP_BRANCH_ON_POLL_LOW 8'hf6
`define DSPID_OP_B 8'hf9
`define DSPID_OP_BLZ 8'hfa
`define DSPID_OP_BLEZ 8'hfb
`define DSPID_OP_BGZ 8'hfc
`define DSPID_OP_BGEZ 8'hfd
`define DSPID_OP_BNZ 8'hfe
`define DSPID_OP_BZ 8'hff
`define DSPID_OP_CALL 8'hf8
`define DSPID_AUX_POINTER_LOAD_IMM_MASK 16'hfffe
`define DSPID_AUX_POINTER_LOAD_IMM_BASE 16'h6880
`define DSPID_BIT_IND 7
`define DSPID_BIT_INC 5
`define DSPID_BIT_DEC 4
`define DSPID_BIT_NAR 3
`define DSPID_BIT_AR_SEL 8
`define DSPID_RST_PC 12'h000
`define DSPID_RST_ACC 32'h0000_0000
`define DSPID_STACK_DEPTH 4
`endif

// file: dspid_pkg.sv
// Types shared by the instruction decoder and its neighbours
package dspid_pkg;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [15:0] operand;
  } dspid_issue_s;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [15:0] data;
  } dspid_store_s;
  typedef struct packed {
    logic aux_reg_selector;
    logic dp;
    logic [15:0] ar0;
    logic [15:0] ar1;
  } dspid_ptr_s;
  typedef enum logic [1:0] {
    DSPID_EXEC = 2'b00,
    DSPID_TARGET = 2'b01,
    DSPID_SECOND = 2'b10
  } dspid_state_e;
endpackage : dspid_pkg

// file: dspid_decoder.sv
// Instruction decode and execute control for the 16-bit fixed-point core
//
// Contract
// - Absolute value of accumulator, one cycle
// - Nibble 0000 adds sign-extended shifted operand
// - High add into upper accumulator half
// - Unsigned add zero-fills operand
// - AND, OR, XOR with accumulator
// - Nibble 0010 loads shifted operand
// - Store upper half shifted by X
// - Store lower sixteen bits unshifted
// - Nibble 0001 subtracts shifted operand
// - Conditional subtract does one divide step
// - High subtract keeps lower half
// - Unsigned subtract zero-extends operand
// - Clear and load upper half
// - Clear and load lower, zero-extended
// - Immediate load into selected auxiliary register
// - Pointer immediate takes least bit
// - Page pointer from operand or immediate
// - Modify touches only auxiliary state
// - Auxiliary nonzero branch, two words
// - Other branches two cycles, two words
// - Call from accumulator pushes, jumps
// - Return pops stacked program counter
// - Bit seven selects direct or indirect
// - Indirect bits increment or decrement
// - Four-level program counter stack
`timescale 1ns/10ps
`include "dspid_consts.svh"
module dspid_decoder
  import dspid_pkg::*;
#(
  parameter int PC_W = 12,
  parameter int STACK_DEPTH = `DSPID_STACK_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Fetch path
  input wire dspid_issue_s issue,
  input wire logic polling_input_n,
  output logic fetch_ready,
  output logic [PC_W-1:0] prog_pc,
  // Datapath view
  output logic [31:0] acc,
  output dspid_ptr_s ptr,
  output dspid_store_s store
);
  if (PC_W < 1 || PC_W > 16 || STACK_DEPTH < 1) begin : g_bad_params
    $error("dspid_decoder: unsupported parameters");
  end

  dspid_state_e state, next_state;
  logic [31:0] next_acc;
  dspid_ptr_s next_ptr;
  dspid_store_s next_store;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [PC_W-1:0] next_stack [STACK_DEPTH];
  logic ovf, next_ovf, next_ready, take_branch, next_take_branch;
  logic [7:0] pending, next_pending;

  function automatic logic [31:0] shift_in(input logic [15:0] op, input logic [3:0] s,
                                           input logic sx);
    logic [31:0] ext;
    ext = sx ? {{16{op[15]}}, op} : {16'h0000, op};
    return ext << s;
  endfunction : shift_in

  function automatic logic [32:0] sum33(input logic [31:0] a, input logic [31:0] b,
                                        input logic sub);
    return sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
  endfunction : sum33

  logic take;
  logic [15:0] w;
  logic [7:0] op8;
  logic [15:0] cur_ar, op;
  logic [32:0] r33;
  logic [31:0] conditional_subtract_op_diff;
  logic cond;
  assign take = issue.valid && fetch_ready;
  assign w = issue.word;
  assign op8 = w[15:8];
  assign op = issue.operand;
  assign cur_ar = ptr.aux_reg_selector ? ptr.ar1 : ptr.ar0;

  always_comb begin
    next_state = state;
    next_acc = acc;
    next_ptr = ptr;
    next_store = '{we: 1'b0, addr: store.addr, data: store.data};
    next_pc = prog_pc;
    next_stack = stack;
    next_ovf = ovf;
    next_ready = 1'b1;
    next_take_branch = take_branch;
    next_pending = pending;
    r33 = '0;
    conditional_subtract_op_diff = '0;
    cond = 1'b0;
    unique case (state)
      DSPID_EXEC: begin
        if (take) begin
          next_pc = prog_pc + 1'b1;
          // Direct form pairs the page pointer with seven address bits
          // address form select
          next_store.addr = w[`DSPID_BIT_IND] ? cur_ar[7:0] : {ptr.dp, w[6:0]};
          if (w == `DSPID_OP_ABS) begin
            next_acc = acc[31] ? 32'h0 - acc : acc;
          end else if (w == `DSPID_OP_ZAC) begin
            next_acc = `DSPID_RST_ACC;
          end else if (w == `DSPID_OP_CALL_FROM_ACCUMULATOR || w == `DSPID_OP_RET) begin
            next_ready = 1'b0;
            next_state = DSPID_SECOND;
            next_pending = w[7:0];
          end else if (op8[7:4] == 4'hf) begin
            // branch word one, condition sampled now
            unique case (op8)
              `DSPID_OP_BRANCH_AUX_NONZERO: cond = (cur_ar[8:0] != 9'h000);
              `DSPID_OP_BV: cond = ovf;
              `DSPID_OP_BRANCH_ON_POLL_LOW: cond = !polling_input_n;
              `DSPID_OP_B, `DSPID_OP_CALL: cond = 1'b1;
              `DSPID_OP_BLZ: cond = acc[31];
              `DSPID_OP_BLEZ: cond = acc[31] || acc == 32'h0;
              `DSPID_OP_BGZ: cond = !acc[31] && acc != 32'h0;
              `DSPID_OP_BGEZ: cond = !acc[31];
              `DSPID_OP_BNZ: cond = acc != 32'h0;
              `DSPID_OP_BZ: cond = acc == 32'h0;
              default: cond = 1'b0;
            endcase
            // auxiliary register counts down on the test
            if (op8 == `DSPID_OP_BRANCH_AUX_NONZERO) begin
              if (ptr.aux_reg_selector) next_ptr.ar1 = {ptr.ar1[15:9], ptr.ar1[8:0] - 9'h001};
              else next_ptr.ar0 = {ptr.ar0[15:9], ptr.ar0[8:0] - 9'h001};
            end
            if (op8 == `DSPID_OP_BV) next_ovf = 1'b0;
            next_take_branch = cond;
            next_pending = op8;
            next_state = DSPID_TARGET;
          end else begin
            unique casez (op8)
              8'b0000_????: begin
                r33 = sum33(acc, shift_in(op, w[11:8], 1'b1), 1'b0);
                next_acc = r33[31:0];
                next_ovf = ovf | (r33[32] ^ r33[31]);
              end
              8'b0001_????: begin
                r33 = sum33(acc, shift_in(op, w[11:8], 1'b1), 1'b1);
                next_acc = r33[31:0];
                next_ovf = ovf | (r33[32] ^ r33[31]);
              end
              8'b0010_????: next_acc = shift_in(op, w[11:8], 1'b1);
              8'b0101_1???: begin
                next_store.we = 1'b1;
                next_store.data = 16'((acc << w[10:8]) >> 16);
              end
              `DSPID_OP_STORE_LOW_WORD: begin
                next_store.we = 1'b1;
                next_store.data = acc[15:0];
              end
              `DSPID_OP_HIGH_PLUS_OP: next_acc = {acc[31:16] + op, acc[15:0]};
              `DSPID_OP_UNSIGNED_PLUS_OP: next_acc = acc + {16'h0000, op};
              `DSPID_OP_HIGH_MINUS_OP: next_acc = {acc[31:16] - op, acc[15:0]};
              `DSPID_OP_UNSIGNED_MINUS_OP: next_acc = acc - {16'h0000, op};
              `DSPID_OP_CONDITIONAL_SUBTRACT_OP: begin
                conditional_subtract_op_diff = acc - {1'b0, op, 15'h0000};
                next_acc = conditional_subtract_op_diff[31] ? {acc[30:0], 1'b0} : {conditional_subtract_op_diff[30:0], 1'b1};
              end
              `DSPID_OP_CLEAR_LOAD_HIGH_OP: next_acc = {op, 16'h0000};
              `DSPID_OP_CLEAR_LOAD_LOW_OP: next_acc = {16'h0000, op};
              `DSPID_OP_AND: next_acc = {16'h0000, acc[15:0] & op};
              `DSPID_OP_OR: next_acc = {acc[31:16], acc[15:0] | op};
              `DSPID_OP_XOR: next_acc = {acc[31:16], acc[15:0] ^ op};
              `DSPID_OP_LOAD_IMM_TO_ACC: next_acc = {24'h00_0000, w[7:0]};
              `DSPID_OP_LDP: next_ptr.dp = op[0];
              `DSPID_OP_PAGE_PTR_LOAD_IMM: next_ptr.dp = w[0];
              8'b0111_000?: begin
                if (w[`DSPID_BIT_AR_SEL]) next_ptr.ar1 = {8'h00, w[7:0]};
                else next_ptr.ar0 = {8'h00, w[7:0]};
              end
              default: ;
            endcase
            if ((w & `DSPID_AUX_POINTER_LOAD_IMM_MASK) == `DSPID_AUX_POINTER_LOAD_IMM_BASE) begin
              next_ptr.aux_reg_selector = w[0];
            end else if (w[`DSPID_BIT_IND] && op8[7:6] != 2'b11 && op8 != `DSPID_OP_LOAD_IMM_TO_ACC
                         && op8 != `DSPID_OP_PAGE_PTR_LOAD_IMM && op8[7:1] != `DSPID_TOP7_AUX_LOAD_IMMEDIATE) begin
              if (w[`DSPID_BIT_INC] && !w[`DSPID_BIT_DEC]) begin
                if (ptr.aux_reg_selector) next_ptr.ar1 = ptr.ar1 + 16'h0001;
                else next_ptr.ar0 = ptr.ar0 + 16'h0001;
              end else if (w[`DSPID_BIT_DEC] && !w[`DSPID_BIT_INC]) begin
                if (ptr.aux_reg_selector) next_ptr.ar1 = ptr.ar1 - 16'h0001;
                else next_ptr.ar0 = ptr.ar0 - 16'h0001;
              end
              if (!w[`DSPID_BIT_NAR]) next_ptr.aux_reg_selector = w[0];
            end
          end
        end
      end
      DSPID_TARGET: begin
        if (take) begin
          next_state = DSPID_EXEC;
          if (take_branch) begin
            next_pc = w[PC_W-1:0];
            if (pending == `DSPID_OP_CALL) begin
              next_stack[0] = prog_pc + 1'b1;
              for (int i = 1; i < STACK_DEPTH; i++) next_stack[i] = stack[i-1];
            end
          end else begin
            next_pc = prog_pc + 1'b1;
          end
        end
      end
      DSPID_SECOND: begin
        next_state = DSPID_EXEC;
        if ({8'h7f, pending} == `DSPID_OP_CALL_FROM_ACCUMULATOR) begin
          next_pc = acc[PC_W-1:0];
          next_stack[0] = prog_pc;
          for (int i = 1; i < STACK_DEPTH; i++) next_stack[i] = stack[i-1];
        end else begin
          // pop and resume; the bottom level is duplicated
          next_pc = stack[0];
          for (int i = 0; i < STACK_DEPTH - 1; i++) next_stack[i] = stack[i+1];
        end
      end
      default: next_state = DSPID_EXEC;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= DSPID_EXEC;
      acc <= `DSPID_RST_ACC;
      ptr <= '0;
      store <= '0;
      prog_pc <= PC_W'(`DSPID_RST_PC);
      ovf <= 1'b0;
      fetch_ready <= 1'b0;
      take_branch <= 1'b0;
      pending <= 8'h00;
      for (int i = 0; i < STACK_DEPTH; i++) stack[i] <= '0;
    end else begin
      state <= next_state;
      acc <= next_acc;
      ptr <= next_ptr;
      store <= next_store;
      prog_pc <= next_pc;
      ovf <= next_ovf;
      fetch_ready <= next_ready;
      take_branch <= next_take_branch;
      pending <= next_pending;
      stack <= next_stack;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic in_exec;
  assign in_exec = take && state == DSPID_EXEC;

  AST_ABS: assert property (in_exec && w == `DSPID_OP_ABS |=>
    acc == ($past(acc[31]) ? 32'h0 - $past(acc) : $past(acc)))
    else $error("absolute value wrong");
  AST_CLEAR_LOAD_HIGH_OP: assert property (in_exec && op8 == `DSPID_OP_CLEAR_LOAD_HIGH_OP |=>
    acc == {$past(op), 16'h0000}) else $error("clear load high wrong");
  AST_STORE_LOW_WORD: assert property (in_exec && op8 == `DSPID_OP_STORE_LOW_WORD |=>
    store.we && store.data == $past(acc[15:0])) else $error("low store wrong");
  AST_UNSIGNED_PLUS_OP: assert property (in_exec && op8 == `DSPID_OP_UNSIGNED_PLUS_OP |=>
    acc == $past(acc) + {16'h0000, $past(op)}) else $error("unsigned add wrong");
  AST_AUX_LOAD_IMMEDIATE: assert property (in_exec && op8 == 8'h71 |=>
    ptr.ar1 == {8'h00, $past(w[7:0])}) else $error("aux immediate wrong");
  AST_PAGE_PTR_LOAD_IMM: assert property (in_exec && op8 == `DSPID_OP_PAGE_PTR_LOAD_IMM |=>
    ptr.dp == $past(w[0])) else $error("page pointer wrong");
  AST_HOLD: assert property (in_exec && w == `DSPID_OP_CALL_FROM_ACCUMULATOR |=>
    !fetch_ready ##1 fetch_ready) else $error("fetch not held");
  AST_CALL_FROM_ACCUMULATOR: assert property (in_exec && w == `DSPID_OP_CALL_FROM_ACCUMULATOR |=> ##1
    prog_pc == $past(acc[PC_W-1:0], 2) && stack[0] == $past(prog_pc, 2) + 1'b1)
    else $error("accumulator call wrong");
  AST_RET: assert property (in_exec && w == `DSPID_OP_RET |=> ##1
    prog_pc == $past(stack[0], 2)) else $error("return wrong");
  AST_B: assert property (in_exec && op8 == `DSPID_OP_B ##1 take |=>
    prog_pc == $past(w[PC_W-1:0])) else $error("branch target wrong");
  AST_INC: assert property (in_exec && w[7] && op8 == `DSPID_OP_MAR && !ptr.aux_reg_selector
    && w[5:3] == 3'b101 |=> ptr.ar0 == $past(ptr.ar0) + 16'h0001)
    else $error("post increment wrong");

  COV_BRANCH: cover property (in_exec && op8 == `DSPID_OP_BRANCH_AUX_NONZERO ##1 take);
  COV_CALL_RET: cover property (in_exec && w == `DSPID_OP_CALL_FROM_ACCUMULATOR ##[2:20]
    in_exec && w == `DSPID_OP_RET);
  COV_CONDITIONAL_SUBTRACT_OP: cover property (in_exec && op8 == `DSPID_OP_CONDITIONAL_SUBTRACT_OP);
endmodule : dspid_decoder

// file: dspid_mem_model.sv
// Data memory model that resolves operands and takes stores
`timescale 1ns/10ps
module dspid_mem_model
  import dspid_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Decoder side
  input wire logic [15:0] word,
  input wire dspid_ptr_s ptr,
  input wire dspid_store_s store,
  output logic [15:0] operand
);
  logic [15:0] mem [256];
  logic [15:0] cur_ar;
  assign cur_ar = ptr.aux_reg_selector ? ptr.ar1 : ptr.ar0;
  assign operand = word[7] ? mem[cur_ar[7:0]] : mem[{ptr.dp, word[6:0]}];
  always @(posedge core_clk) begin
    if (store.we === 1'b1) begin
      mem[store.addr] <= store.data;
    end
  end
endmodule : dspid_mem_model

// file: tb_top.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
module tb_top;
  import dspid_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic iss_valid = 1'b0;
  logic [15:0] iss_word = 16'h0000;
  logic polling_input_n = 1'b1;
  logic [15:0] opnd;
  logic fetch_ready;
  logic [11:0] prog_pc;
  logic [31:0] acc;
  dspid_ptr_s ptr;
  dspid_store_s store;
  dspid_issue_s issue;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rs = 32'h4df7;
  logic [31:0] m_acc = 32'h0;
  logic [11:0] m_pc = 12'h0;
  logic [11:0] stk[$];
  logic [15:0] ops [16] = '{16'h0000, 16'h1000, 16'h2000, 16'h6000, 16'h6100, 16'h6200,
    16'h6300, 16'h6400, 16'h6500, 16'h6600, 16'h7800, 16'h7900, 16'h7a00, 16'h7e00,
    16'h7f88, 16'h7f89};
  logic [7:0] brs [8] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff, 8'hf6};
  assign issue = '{valid: iss_valid, word: iss_word, operand: opnd};
  always #4 core_clk = ~core_clk;
  dspid_decoder u_dut (.core_clk(core_clk), .arst_n(arst_n), .issue(issue),
    .polling_input_n(polling_input_n), .fetch_ready(fetch_ready), .prog_pc(prog_pc),
    .acc(acc), .ptr(ptr), .store(store));
  dspid_mem_model u_mem (.core_clk(core_clk), .word(iss_word), .ptr(ptr), .store(store),
    .operand(opnd));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic [31:0] alu(input logic [15:0] w, input logic [31:0] a,
    input logic [15:0] d);
    logic [31:0] sx;
    logic [31:0] zx;
    logic [31:0] hi;
    logic [31:0] df;
    sx = {{16{d[15]}}, d} << w[11:8];
    zx = {16'h0, d};
    hi = {d, 16'h0};
    df = a - {1'b0, d, 15'h0};
    if (w == 16'h7f88) return a[31] ? -a : a;
    if (w == 16'h7f89) return 32'h0;
    case (w[15:12])
      4'h0: return a + sx;
      4'h1: return a - sx;
      4'h2: return sx;
      default: ;
    endcase
    case (w[15:8])
      8'h60: return a + hi;
      8'h61: return a + zx;
      8'h62: return a - hi;
      8'h63: return a - zx;
      8'h64: return df[31] ? a << 1 : (df << 1) + 32'h1;
      8'h65: return hi;
      8'h66: return zx;
      8'h78: return a ^ zx;
      8'h79: return a & zx;
      8'h7a: return a | zx;
      8'h7e: return {24'h0, w[7:0]};
      default: return a;
    endcase
  endfunction : alu
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits are bounded to eight cycles; a decoder still not ready is counted as a mismatch here
  task automatic put(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge core_clk);
    while (fetch_ready !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    if (fetch_ready !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, fetch_ready, 1'b1);
    end
    iss_valid = 1'b1;
    iss_word = w;
    m_pc = m_pc + 12'h1;
    @(posedge core_clk);
  endtask : put
  task automatic idle();
    @(negedge core_clk);
    iss_valid = 1'b0;
  endtask : idle
  task automatic step(input logic [15:0] w, input logic [15:0] d);
    logic [7:0] a;
    a = ptr.aux_reg_selector ? ptr.ar1[7:0] : ptr.ar0[7:0];
    if (!w[7]) a = {ptr.dp, w[6:0]};
    u_mem.mem[a] = d;
    put(w);
    idle();
    m_acc = alu(w, m_acc, d);
    chk(acc, m_acc);
    chk(32'(prog_pc), 32'(m_pc));
  endtask : step
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    logic [15:0] k0;
    logic tk;
    int sh;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    chk(acc, 32'h0);
    step(16'h6e01, 16'h0);
    chk(32'(ptr.dp), 32'h1);
    r = rnd();
    step(16'h6f05, r[15:0]);
    chk(32'(ptr.dp), 32'(r[0]));
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      w = ops[r[3:0]];
      if (w[7:0] == 8'h00) w = w | {4'h0, w[15:14] == 2'b00 ? r[7:4] : 4'h0, 1'b0, r[14:8]};
      step(w, r[31:16]);
    end
    $display("test alu done");
    r = rnd();
    k0 = {8'h0, r[7:0]};
    step({7'h38, 1'b0, r[7:0]}, 16'h0);
    step({7'h38, 1'b1, r[15:8]}, 16'h0);
    chk(32'(ptr.ar1), 32'(r[15:8]));
    step(16'h6881, 16'h0);
    chk(32'(ptr.aux_reg_selector), 32'h1);
    step(16'h6880, 16'h0);
    step(16'h68a8, r[31:16]);
    chk(32'(ptr.ar0), 32'(k0 + 16'h1));
    step(16'h6891, r[31:16]);
    chk(32'(ptr.ar0), 32'(k0));
    chk(32'(ptr.aux_reg_selector), 32'h1);
    step(16'h00a8, r[31:16]);
    chk(32'(ptr.ar1), 32'(r[15:8]) + 32'h1);
    for (int x = 0; x < 4; x++) begin
      r = rnd();
      sh = (x == 2) ? 4 : x;
      w = (x == 3) ? {9'h0a0, r[6:0]} : {5'h0b, 3'(sh), 1'b0, r[6:0]};
      put(w);
      idle();
      r = m_acc << sh;
      chk(32'(store.we), 32'h1);
      chk(32'(store.addr), 32'({ptr.dp, w[6:0]}));
      chk(32'(store.data), (x == 3) ? 32'(m_acc[15:0]) : 32'(r[31:16]));
    end
    $display("test aux and store done");
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      step(16'h2000, r[20] ? 16'h0 : r[15:0]);
      w = {brs[r[18:16]], 8'h00};
      polling_input_n = r[21];
      case (w[15:8])
        8'hfa: tk = $signed(m_acc) < 0;
        8'hfb: tk = $signed(m_acc) <= 0;
        8'hfc: tk = $signed(m_acc) > 0;
        8'hfd: tk = $signed(m_acc) >= 0;
        8'hfe: tk = m_acc != 32'h0;
        8'hff: tk = m_acc == 32'h0;
        8'hf6: tk = !r[21];
        default: tk = 1'b1;
      endcase
      put(w);
      put({4'h0, r[31:20]});
      idle();
      if (tk) m_pc = r[31:20];
      chk(32'(prog_pc), 32'(m_pc));
    end
    step(16'h7002, 16'h0);
    step(16'h6880, 16'h0);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      put(16'hf400);
      put({4'h0, r[11:0]});
      idle();
      if (i < 2) m_pc = r[11:0];
      chk(32'(prog_pc), 32'(m_pc));
      if (i < 2) chk(32'(ptr.ar0), 32'(1 - i));
    end
    $display("test branch done");
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      if (i < 5) step(16'h6610, {4'h0, r[11:0]});
      put(i < 5 ? 16'h7f8c : 16'h7f8d);
      idle();
      chk(32'(fetch_ready), 32'h0);
      if (i < 5) begin
        stk.push_front(m_pc);
        if (stk.size() > 4) void'(stk.pop_back());
        m_pc = r[11:0];
      end else begin
        m_pc = stk[0];
        if (stk.size() > 1) void'(stk.pop_front());
      end
      idle();
      idle();
      chk(32'(prog_pc), 32'(m_pc));
    end
    // Forced overflow: first overflow branch taken and clears it, second falls through
    step(16'h6510, 16'h7fff);
    step(16'h0f10, 16'h7fff);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      put(i == 2 ? 16'hf800 : 16'hf500);
      put({4'h0, r[11:0]});
      idle();
      if (i == 2) stk.push_front(m_pc);
      if (i != 1) m_pc = r[11:0];
      chk(32'(prog_pc), 32'(m_pc));
    end
    put(16'h7f8d);
    idle();
    idle();
    m_pc = stk[0];
    chk(32'(prog_pc), 32'(m_pc));
    $display("test call done");
    print_verdict();
  end
endmodule : tb_top
